// File: hw/dac_consts.svh
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

`define WORD_BITS 12
`define WORD_CNT_W 4
`define CMD_MSB 11
`define CMD_LSB 8
`define ADDR_MSB 11
`define ADDR_LSB 10
`define DATA_MSB 7
`define CODE_ZERO 8'h00
`define WORD_ZERO 12'h000
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_MAX 4'hF
`define CNT_WORD 4'hC
`define CMD_PASS 4'h0
`define CMD_SW_LOAD 4'h4
`define CMD_LOAD_ALL 4'h8
`define CMD_SHUTDOWN 4'hC
`define CMD_USER_LOW 4'h2
`define CMD_USER_HIGH 4'h6
`define CMD_MODE1 4'hE
`define CMD_MODE0 4'hA
`define CTRL_INPUT_ONLY 2'h1
`define CTRL_INPUT_DAC 2'h3
`define SHIFT_TAP 11

`endif

// File: hw/dac_pkg.sv
package dac_pkg;
    typedef logic [7:0] code_t;
    typedef logic [11:0] word_t;
    typedef enum logic [1:0] {
        CH_FIRST = 2'b00,
        CH_SECOND = 2'b01,
        CH_THIRD = 2'b10,
        CH_FOURTH = 2'b11
    } channel_e;
    typedef enum logic [0:0] {
        EDGE_FALL = 1'b0,
        EDGE_RISE = 1'b1
    } out_edge_e;
endpackage

// File: hw/pin_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= RESET_VAL;
            pin_sync_out <= RESET_VAL;
        end
        else
        begin
            meta_q <= pin_in;
            pin_sync_out <= meta_q;
        end
    end
endmodule // pin_sync

// File: hw/quad_dac_serial_command_decoder.sv
// What this block does
// - Control 01 loads addressed input register only
// - Control 11 loads input, updates all DACs
// - Command 0100 copies inputs to DACs, wakes
// - Command 1000 writes byte to all DACs
// - Command 1100 shuts down if permit high
// - Commands 0010/0110 drive user output low/high
// - Command 0000 changes nothing, data passes through
// - Command 1110 selects rising-edge output, updates DACs
// - Command 1010 selects falling-edge output, updates DACs
// - Output edge mode changes only by mode commands
// - Data byte ignored for dataless commands
// - Load pin low makes DAC registers transparent
// - Clear pin low zeroes input and DAC registers
// - Words shift MSB first on rising clock
// - Select rising edge executes shift register contents
// - Serial output lags input, never floats, holds
// - Power-on clears everything, selects falling-edge mode
`timescale 1ns/10ps
`include "dac_consts.svh"

module quad_dac_serial_command_decoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic link_din,
    output logic link_dout,
    // Control pins
    input wire logic load_strobe_n,
    input wire logic clear_all_n,
    input wire logic shutdown_permit,
    output logic user_logic_output,
    // Converter state
    output dac_pkg::code_t dac_code_a,
    output dac_pkg::code_t dac_code_b,
    output dac_pkg::code_t dac_code_c,
    output dac_pkg::code_t dac_code_d,
    output logic shutdown,
    output dac_pkg::out_edge_e out_edge
);
    import dac_pkg::*;

    // =========================================
    // Pin synchronisers
    logic [4:0] pins_s;
    logic sclk_s, sel_n_s, din_s, load_n_s, clear_n_s, shutdown_s;
    logic link_din_q1, link_din_q2;

    // Permit idles low, so its stage resets low to avoid a false permit
    pin_sync #(.WIDTH(5), .RESET_VAL(5'h1C)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({link_sel_n, load_strobe_n, clear_all_n, shutdown_permit, link_clk}),
        .pin_sync_out(pins_s)
    );
    assign sel_n_s = pins_s[4];
    assign load_n_s = pins_s[3];
    assign clear_n_s = pins_s[2];
    assign shutdown_s = pins_s[1];
    assign sclk_s = pins_s[0];
    assign din_s = link_din_q2;

    // Data path held the same two stages as the clock so it is stable at the edge
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_din_q1 <= 1'b0;
            link_din_q2 <= 1'b0;
        end
        else
        begin
            link_din_q1 <= link_din;
            link_din_q2 <= link_din_q1;
        end
    end

    // =========================================
    // Edge detection
    logic sclk_q, sel_n_q;
    logic sclk_rise, sclk_fall, sel_rise;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk_s;
            sel_n_q <= sel_n_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_q && !sel_n_s;
    assign sclk_fall = !sclk_s && sclk_q && !sel_n_s;
    assign sel_rise = sel_n_s && !sel_n_q;

    // =========================================
    // Shift register
    word_t shift_q;
    logic [3:0] bit_cnt_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            shift_q <= `WORD_ZERO;
        else if (sclk_rise)
            shift_q <= {shift_q[`WORD_BITS-2:0], din_s};
    end

    // Bits seen in the current frame, saturating; used only by checks
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bit_cnt_q <= `CNT_ZERO;
        else if (sel_rise)
            bit_cnt_q <= `CNT_ZERO;
        else if (sclk_rise && bit_cnt_q != `CNT_MAX)
            bit_cnt_q <= bit_cnt_q + `CNT_ONE;
    end

    // =========================================
    // Serial output
    // Mode 0 shows the bit half a cycle after it left, so it is kept a stage
    logic spill_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            spill_q <= 1'b0;
        else if (sclk_rise)
            spill_q <= shift_q[`SHIFT_TAP];
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            link_dout <= 1'b0;
        else if (out_edge == EDGE_RISE && sclk_rise)
            link_dout <= shift_q[`SHIFT_TAP];
        else if (out_edge == EDGE_FALL && sclk_fall)
            link_dout <= spill_q;
    end

    // =========================================
    // Command decode
    logic [3:0] cmd;
    logic [1:0] ctrl;
    channel_e addr;
    code_t data;
    logic load_input, upd_all, load_all, go_down, wake;

    assign cmd = shift_q[`CMD_MSB:`CMD_LSB];
    assign ctrl = cmd[1:0];
    assign addr = channel_e'(shift_q[`ADDR_MSB:`ADDR_LSB]);
    assign data = shift_q[`DATA_MSB:0];

    always_comb
    begin
        load_input = 1'b0;
        upd_all = 1'b0;
        load_all = 1'b0;
        go_down = 1'b0;
        wake = 1'b0;
        if (sel_rise)
        begin
            if (ctrl == `CTRL_INPUT_ONLY)
                load_input = 1'b1;
            else if (ctrl == `CTRL_INPUT_DAC)
            begin
                load_input = 1'b1;
                upd_all = 1'b1;
            end
            else
            begin
                // Data byte ignored on every branch below but load-all
                case (cmd)
                    `CMD_SW_LOAD:
                    begin
                        upd_all = 1'b1;
                        wake = 1'b1;
                    end
                    `CMD_LOAD_ALL:
                    begin
                        load_all = 1'b1;
                        wake = 1'b1;
                    end
                    `CMD_SHUTDOWN: go_down = shutdown_s;
                    `CMD_MODE1: upd_all = 1'b1;
                    `CMD_MODE0: upd_all = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // =========================================
    // Input and converter registers
    code_t in_q [4];
    code_t in_d [4];
    code_t dac_q [4];

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            in_d[i] = in_q[i];
            if (load_input && addr == channel_e'(i))
                in_d[i] = data;
        end
    end

    // Clear pin is synchronised, so it takes effect two core cycles late
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                in_q[i] <= `CODE_ZERO;
        end
        else if (!clear_n_s)
        begin
            for (int i = 0; i < 4; i++)
                in_q[i] <= `CODE_ZERO;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                in_q[i] <= in_d[i];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                dac_q[i] <= `CODE_ZERO;
        end
        else if (!clear_n_s)
        begin
            for (int i = 0; i < 4; i++)
                dac_q[i] <= `CODE_ZERO;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (load_all)
                    dac_q[i] <= data;
                else if (upd_all || !load_n_s)
                    dac_q[i] <= in_d[i];
            end
        end
    end

    assign dac_code_a = dac_q[0];
    assign dac_code_b = dac_q[1];
    assign dac_code_c = dac_q[2];
    assign dac_code_d = dac_q[3];

    // =========================================
    // Shutdown, user output and edge mode
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            shutdown <= 1'b0;
        else if (go_down)
            shutdown <= 1'b1;
        else if (wake)
            shutdown <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            user_logic_output <= 1'b0;
        else if (sel_rise && cmd == `CMD_USER_LOW)
            user_logic_output <= 1'b0;
        else if (sel_rise && cmd == `CMD_USER_HIGH)
            user_logic_output <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            out_edge <= EDGE_FALL;
        else if (sel_rise && cmd == `CMD_MODE1)
            out_edge <= EDGE_RISE;
        else if (sel_rise && cmd == `CMD_MODE0)
            out_edge <= EDGE_FALL;
    end

    // =========================================
    // Checks
    sequence s_exec(logic [3:0] c);
        sel_rise && cmd == c && clear_n_s;
    endsequence

    a_mode_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(sel_rise && (cmd == `CMD_MODE1 || cmd == `CMD_MODE0)) |=> $stable(out_edge))
        else $error("edge mode changed without mode command");
    a_mode_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_MODE1) |=> out_edge == EDGE_RISE)
        else $error("mode 1 not selected");
    a_shutdown_permit: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_SHUTDOWN) |=> shutdown == ($past(shutdown) || $past(shutdown_s)))
        else $error("shutdown permit mishandled");
    a_load_all_dac: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_LOAD_ALL) |=> dac_code_a == $past(data) && dac_code_d == $past(data)
            && !shutdown)
        else $error("load all failed");
    a_upo_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_USER_HIGH) |=> user_logic_output && $stable(dac_code_a))
        else $error("user output not high");
    a_pass_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_PASS) && load_n_s |=> $stable(dac_code_b) && $stable(in_q[1]))
        else $error("pass command changed registers");
    a_input_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_rise && ctrl == `CTRL_INPUT_ONLY && load_n_s && clear_n_s
            |=> $stable(dac_code_c) && in_q[$past(addr)] == $past(data))
        else $error("input-only load wrong");
    a_clear_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clear_n_s |=> dac_code_a == `CODE_ZERO && in_q[3] == `CODE_ZERO)
        else $error("clear did not zero registers");
    a_sw_update: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_exec(`CMD_SW_LOAD) |=> dac_code_b == in_q[1] && !shutdown)
        else $error("software load failed");
    a_dout_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_n_s && sel_n_q |=> $stable(link_dout))
        else $error("serial output moved while deselected");
    a_whole_word: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_rise |-> bit_cnt_q >= `CNT_WORD)
        else $error("command executed from a partial word");
endmodule // quad_dac_serial_command_decoder

// File: verif/host_model.sv
`timescale 1ns/10ps
// ========
// Serial master on the link pins
module host_model (
    // Clock
    input wire logic core_clk,
    // Link pins
    output logic link_clk,
    output logic link_sel_n,
    output logic link_din,
    input wire logic link_dout
);
    import dac_pkg::*;
    word_t rx_rise;
    word_t rx_fall;
    initial
    begin
        link_clk = 1'h0;
        link_sel_n = 1'h1;
        link_din = 1'h0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic open_frame();
        link_sel_n <= 1'h0;
        wait_n(6);
    endtask
    // High for 4 cycles, low for 8; clock rests low between frames
    task automatic shift(input word_t w);
        for (int i = 11; i >= 0; i--)
        begin
            link_din <= w[i];
            wait_n(4);
            link_clk <= 1'h1;
            wait_n(4);
            rx_rise = {rx_rise[10:0], link_dout};
            link_clk <= 1'h0;
            wait_n(4);
            rx_fall = {rx_fall[10:0], link_dout};
        end
    endtask
    // Shift register runs as a command now, so words go whole
    task automatic close_frame();
        link_sel_n <= 1'h1;
        link_din <= ~link_din;
        wait_n(10);
    endtask
endmodule // host_model

// File: verif/quad_dac_serial_command_decoder_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) \
        begin \
            failures++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
        end \
    end

module quad_dac_serial_command_decoder_tb;
    import dac_pkg::*;
    logic core_clk, sys_rst, link_clk, link_sel_n, link_din, link_dout;
    logic load_strobe_n, clear_all_n, shutdown_permit, user_logic_output, shutdown;
    out_edge_e out_edge, exp_edge;
    code_t dac_seen [4];
    code_t exp_inp [4];
    code_t exp_dac [4];
    logic exp_upo, exp_shut;
    int failures, checks_done;

    quad_dac_serial_command_decoder quad_dac_serial_command_decoder_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .link_sel_n(link_sel_n), .link_din(link_din), .link_dout(link_dout),
        .load_strobe_n(load_strobe_n), .clear_all_n(clear_all_n),
        .shutdown_permit(shutdown_permit), .user_logic_output(user_logic_output),
        .dac_code_a(dac_seen[0]), .dac_code_b(dac_seen[1]), .dac_code_c(dac_seen[2]),
        .dac_code_d(dac_seen[3]), .shutdown(shutdown), .out_edge(out_edge));
    host_model host_model_inst (.core_clk(core_clk), .link_clk(link_clk),
        .link_sel_n(link_sel_n), .link_din(link_din), .link_dout(link_dout));

    always #4 core_clk = ~core_clk;

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic compare_all(input string nm);
        for (int i = 0; i < 4; i++)
            `CHK(nm, exp_dac[i], dac_seen[i])
        `CHK(nm, exp_upo, user_logic_output)
        `CHK(nm, exp_shut, shutdown)
        `CHK(nm, exp_edge, out_edge)
    endtask
    // ========
    // Expected register model
    function automatic void apply(input word_t w);
        case (w[11:8])
            4'h4, 4'h8: exp_shut = 1'h0;
            4'hC: exp_shut = exp_shut | shutdown_permit;
            4'h2, 4'h6: exp_upo = w[10];
            4'hE, 4'hA: exp_edge = out_edge_e'(w[10]);
            default: ;
        endcase
        if (w[8])
            exp_inp[w[11:10]] = w[7:0];
        if (w[9:8] == 2'h3 || w[11:8] inside {4'h4, 4'hE, 4'hA} || !load_strobe_n)
            exp_dac = exp_inp;
        if (w[11:8] == 4'h8)
            exp_dac = '{4{w[7:0]}};
    endfunction
    task automatic run_cmd(input word_t w);
        host_model_inst.open_frame();
        host_model_inst.shift(w);
        host_model_inst.close_frame();
        apply(w);
        compare_all($sformatf("cmd %h", w));
    endtask
    // Downstream word leaves on the output while a pass-through word stays
    task automatic chain_check(input word_t fwd);
        host_model_inst.open_frame();
        host_model_inst.shift(fwd);
        host_model_inst.shift(12'h0FF);
        host_model_inst.close_frame();
        compare_all("pass through");
        `CHK("dout fall", fwd, host_model_inst.rx_fall)
        `CHK("dout rise", exp_edge ? fwd[10:0] : fwd[11:1], host_model_inst.rx_rise[10:0])
        wait_n(20);
        `CHK("dout hold", fwd[0], link_dout)
    endtask
    // ========
    // Scenarios
    task automatic t_inputs();
        run_cmd(12'h1A1);
        run_cmd(12'h5B2);
        run_cmd(12'h9C3);
        run_cmd(12'hDD4);
        run_cmd(12'h3E5);
        run_cmd(12'h977);
        run_cmd(12'h4FF);
        $display("test inputs done");
    endtask
    task automatic t_modes();
        run_cmd(12'h966);
        run_cmd(12'hE3C);
        chain_check(12'hB4D);
        run_cmd(12'hA5A);
        chain_check(12'h6B2);
        run_cmd(12'hE00);
        $display("test modes done");
    endtask
    task automatic t_upo_shutdown();
        run_cmd(12'h6AA);
        run_cmd(12'h255);
        run_cmd(12'h6C3);
        run_cmd(12'hC5A);
        shutdown_permit <= 1'h1;
        wait_n(4);
        run_cmd(12'hCA5);
        run_cmd(12'h4C3);
        run_cmd(12'hC00);
        run_cmd(12'h800);
        run_cmd(12'hC00);
        run_cmd(12'h83C);
        $display("test upo and shutdown done");
    endtask
    task automatic t_load_clear();
        load_strobe_n <= 1'h0;
        wait_n(6);
        exp_dac = exp_inp;
        compare_all("load low");
        run_cmd(12'h581);
        load_strobe_n <= 1'h1;
        wait_n(4);
        run_cmd(12'h1F0);
        clear_all_n <= 1'h0;
        wait_n(6);
        exp_inp = '{default: 8'h00};
        exp_dac = '{default: 8'h00};
        compare_all("clear");
        clear_all_n <= 1'h1;
        wait_n(4);
        run_cmd(12'h4AB);
        $display("test load and clear done");
    endtask

    initial
    begin
        core_clk = 1'h0;
        sys_rst = 1'h1;
        load_strobe_n = 1'h1;
        clear_all_n = 1'h1;
        shutdown_permit = 1'h0;
        failures = 0;
        checks_done = 0;
        exp_inp = '{default: 8'h00};
        exp_dac = '{default: 8'h00};
        exp_upo = 1'h0;
        exp_shut = 1'h0;
        exp_edge = EDGE_FALL;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst <= 1'h0;
        wait_n(4);
        compare_all("reset");
        `CHK("reset dout", 1'h0, link_dout)
        $display("test reset done");
        t_inputs();
        t_modes();
        t_upo_shutdown();
        t_load_clear();
        give_verdict();
    end
    // Whole run takes about 4500 cycles
    initial
    begin
        #(20000 * 8);
        failures++;
        give_verdict();
    end
endmodule // quad_dac_serial_command_decoder_tb
